// ==== design/psc_pkg.sv ====
// Behaviour
// - Single-write select picks burst-read/single-write or burst-read/burst-write.
// - Single-write style: writes move one word; reads keep burst length.
// - Write-enable style bit picks level control or single-clock control.
// - Output enable rising mid read suspends burst; data outputs float.
// - Read suspend acts only after first word or after dummy waits.
// - Output enable low again resumes read at the suspended address.
// - Write enable rising suspends burst write after first word; low resumes.
// - Write suspend and resume exist only with level-controlled write enable.
// - Chip select rising ends a burst read; continuous reads never self-end.
// - Chip select rising ends a burst write; continuous writes run until then.
// - Wait output low means busy, high means ready, during bursts.
// - Wait floats with chip select high; low after select or address-valid falls.
// - Wait low: no read data or write acceptance on next cycle.
// - Wait goes high one cycle before each data word.
// - While suspended, wait keeps its level from the cycle before.
// - Asynchronous mode keeps the wait output high impedance always.
// - Continuous bursts insert dummy waits crossing first 16-word boundary.
// - Linear addressing; lengths 8 and 16 wrap in block; continuous does not.
// - Write latency equals read latency minus one.
// - Dummy wait count follows start offset and latency; latency five gives one at B.
package psc_pkg;
  localparam int ADDR_W = 23;
  localparam logic [1:0] BL_8    = 2'h0;
  localparam logic [1:0] BL_16   = 2'h1;
  localparam logic [1:0] BL_CONT = 2'h2;
  localparam logic [3:0] OFS_LAST  = 4'hf;
  // Dummy waits = offset + latency - 15 when positive
  localparam logic [4:0] DUMMY_BIAS = 5'h0f;
  typedef enum logic [2:0] {PSC_IDLE, PSC_LAT, PSC_XFER, PSC_DUMMY, PSC_DONE} psc_state_e;
  typedef struct packed {
    logic       sync_mode;
    logic       single_write_select;
    logic       write_enable_style;
    logic [1:0] burst_length_field;
    logic [3:0] read_latency_count;
  } psc_mode_s;
  typedef struct packed {
    logic chip_select_n;
    logic address_valid_n;
    logic oe_n;
    logic we_n;
    logic clk;
  } psc_pins_s;
endpackage

// ==== design/psc_burst_ctrl.sv ====
`timescale 1ns/1ps
module psc_burst_ctrl #(
  parameter int ADDR_W = psc_pkg::ADDR_W
) (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_n_i,
  input  wire psc_pkg::psc_mode_s  mode_i,
  input  wire psc_pkg::psc_pins_s  pins_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  output logic                     wait_n_o,
  output logic                     wait_oe_n_o,
  output logic                     dq_oe_n_o,
  output logic                     word_strobe_o,
  output logic                     word_is_write_o,
  output logic [ADDR_W-1:0]        word_addr_o,
  output logic                     busy_o
);
  psc_pkg::psc_pins_s meta;
  psc_pkg::psc_pins_s pin;
  logic               clk_d;
  logic               cs_d;
  logic               adv_d;
  logic [ADDR_W-1:0]  addr_meta;
  logic [ADDR_W-1:0]  addr_pin;
  psc_pkg::psc_state_e state;
  psc_pkg::psc_state_e next_state;
  logic [ADDR_W-1:0]  addr;
  logic [3:0]         lat_cnt;
  logic [4:0]         word_cnt;
  logic [4:0]         dummy_cnt;
  logic               is_write;
  logic               crossed;
  logic [4:0]         dummy_need;

  // Pins pass two flops; link clock edges found from sampled level
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta  <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      pin   <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      clk_d <= 1'b0;
      cs_d  <= 1'b1;
      adv_d <= 1'b1;
      addr_meta <= '0;
      addr_pin  <= '0;
    end else begin
      meta  <= pins_i;
      pin   <= meta;
      // Address rides the same two flops so it lines up with the edge
      addr_meta <= addr_i;
      addr_pin  <= addr_meta;
      clk_d <= pin.clk;
      cs_d  <= pin.chip_select_n;
      adv_d <= pin.address_valid_n;
    end
  end

  wire       edge_w     = pin.clk & ~clk_d;
  wire       cs_fall    = ~pin.chip_select_n & cs_d;
  wire       adv_fall   = ~pin.chip_select_n & ~pin.address_valid_n & adv_d;
  wire       cs_rise    = pin.chip_select_n & ~cs_d;
  wire       start      = edge_w & ~pin.chip_select_n & ~pin.address_valid_n & mode_i.sync_mode;
  wire       wr_req     = ~pin.we_n;
  wire [3:0] wr_lat     = mode_i.read_latency_count - 4'h1;
  // Latched direction: single-clock write enable is low for one edge only
  wire [3:0] lat_goal   = is_write ? wr_lat : mode_i.read_latency_count;
  // Write suspend only under level control
  wire       wr_susp    = is_write & pin.we_n & mode_i.write_enable_style & (word_cnt != 5'h0);
  wire       rd_susp    = ~is_write & pin.oe_n & (word_cnt != 5'h0);
  wire       suspended  = wr_susp | rd_susp;
  wire [4:0] burst_len  = (is_write & mode_i.single_write_select) ? 5'h01 :
                          (mode_i.burst_length_field == psc_pkg::BL_8) ? 5'h08 : 5'h10;
  wire       cont       = (mode_i.burst_length_field == psc_pkg::BL_CONT)
                          & ~(is_write & mode_i.single_write_select);
  wire [4:0] ofs_lat    = {1'b0, addr[3:0]} + {1'b0, mode_i.read_latency_count};
  wire       last_word  = ~cont & (word_cnt == burst_len - 5'h01);
  wire       at_bound   = cont & ~crossed & (addr[3:0] == psc_pkg::OFS_LAST);
  wire [ADDR_W-1:0] addr_inc = addr + {{(ADDR_W-1){1'b0}}, 1'b1};
  // Wrap inside aligned block for fixed lengths
  wire [ADDR_W-1:0] next_addr =
    cont ? addr_inc :
    (burst_len == 5'h08) ? {addr[ADDR_W-1:3], addr_inc[2:0]} :
    (burst_len == 5'h10) ? {addr[ADDR_W-1:4], addr_inc[3:0]} : addr;

  assign dummy_need = (ofs_lat > psc_pkg::DUMMY_BIAS) ? ofs_lat - psc_pkg::DUMMY_BIAS : 5'h00;

  always_comb begin
    next_state = state;
    unique case (state)
      psc_pkg::PSC_IDLE:  if (start) next_state = psc_pkg::PSC_LAT;
      psc_pkg::PSC_LAT:   if (edge_w && lat_cnt == lat_goal - 4'h1) next_state = psc_pkg::PSC_XFER;
      psc_pkg::PSC_XFER:  if (edge_w && !suspended) begin
        if (last_word) next_state = psc_pkg::PSC_DONE;
        else if (at_bound && dummy_cnt != 5'h0) next_state = psc_pkg::PSC_DUMMY;
      end
      psc_pkg::PSC_DUMMY: if (edge_w && dummy_cnt == 5'h1) next_state = psc_pkg::PSC_XFER;
      psc_pkg::PSC_DONE:  next_state = psc_pkg::PSC_DONE;
    endcase
    if (pin.chip_select_n) next_state = psc_pkg::PSC_IDLE;
    else if (adv_fall && state != psc_pkg::PSC_IDLE) next_state = psc_pkg::PSC_IDLE;
  end

  wire xfer_now = (state == psc_pkg::PSC_XFER) & edge_w & ~suspended & ~pin.chip_select_n;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state     <= psc_pkg::PSC_IDLE;
      addr      <= '0;
      lat_cnt   <= 4'h0;
      word_cnt  <= 5'h0;
      dummy_cnt <= 5'h0;
      is_write  <= 1'b0;
      crossed   <= 1'b0;
    end else begin
      state <= next_state;
      if (start && state == psc_pkg::PSC_IDLE) begin
        addr     <= addr_pin;
        lat_cnt  <= 4'h1;
        word_cnt <= 5'h0;
        is_write <= wr_req;
        crossed  <= 1'b0;
      end else if (state == psc_pkg::PSC_LAT && edge_w) begin
        lat_cnt   <= lat_cnt + 4'h1;
        dummy_cnt <= dummy_need;
      end else if (xfer_now) begin
        addr     <= next_addr;
        word_cnt <= word_cnt + 5'h1;
        if (at_bound) crossed <= 1'b1;
      end else if (state == psc_pkg::PSC_DUMMY && edge_w) begin
        dummy_cnt <= dummy_cnt - 5'h1;
      end
    end
  end

  // Wait output; ready one cycle before data
  wire lat_ready = (state == psc_pkg::PSC_LAT) & (lat_cnt >= lat_goal - 4'h1);
  wire xfer_rdy  = (state == psc_pkg::PSC_XFER) & ~(at_bound & dummy_cnt != 5'h0);
  wire dummy_rdy = (state == psc_pkg::PSC_DUMMY) & (dummy_cnt == 5'h1);
  wire ready_lvl = lat_ready | xfer_rdy | dummy_rdy;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wait_n_o        <= 1'b1;
      wait_oe_n_o     <= 1'b1;
      dq_oe_n_o       <= 1'b1;
      word_strobe_o   <= 1'b0;
      word_is_write_o <= 1'b0;
      word_addr_o     <= '0;
      busy_o          <= 1'b0;
    end else begin
      wait_oe_n_o <= pin.chip_select_n | ~mode_i.sync_mode;
      if (cs_fall || adv_fall) wait_n_o <= 1'b0;
      else if (state == psc_pkg::PSC_IDLE) wait_n_o <= 1'b0;
      else if (!suspended && edge_w) wait_n_o <= ready_lvl & (state != psc_pkg::PSC_DONE);
      dq_oe_n_o <= is_write | pin.oe_n | pin.chip_select_n |
                   (state != psc_pkg::PSC_XFER && state != psc_pkg::PSC_DONE);
      word_strobe_o   <= xfer_now;
      word_is_write_o <= is_write;
      word_addr_o     <= addr;
      busy_o          <= (state != psc_pkg::PSC_IDLE) & (state != psc_pkg::PSC_DONE);
    end
  end
  wire unused_cs_rise = cs_rise;
endmodule // psc_burst_ctrl

// ==== dv/psc_host_model.sv ====
`timescale 1ns/1ps
module psc_host_model (
  input  wire logic          sys_clk_i,
  input  wire logic          go_i,
  input  wire logic          we_n_i,
  input  wire logic          oe_n_i,
  input  wire logic [22:0]   addr_i,
  output psc_pkg::psc_pins_s pins_o,
  output logic [22:0]        addr_o
);
  logic [2:0] ph = 3'h0;
  logic       lclk = 1'b0;
  logic       seen = 1'b0;
  wire  [2:0] ph_nx = ph + 3'h1;
  // Link clock stands low outside a frame
  always @(negedge sys_clk_i) begin
    ph <= go_i ? ph_nx : 3'h0;
    lclk <= go_i && ph_nx[2];
    // Address and address-valid held through the whole latch pulse
    seen <= go_i && (seen || (lclk && !ph_nx[2]));
  end
  assign pins_o = {!go_i, !go_i || seen, oe_n_i, we_n_i, lclk};
  // Address not held after the latch pulse ends
  assign addr_o = seen ? ~addr_i : addr_i;
endmodule // psc_host_model

// ==== dv/psc_burst_ctrl_chk.sv ====
`timescale 1ns/1ps
module psc_burst_ctrl_chk #(parameter int ADDR_W = psc_pkg::ADDR_W) (
  input wire logic               sys_clk_i,
  input wire logic               rst_n_i,
  input wire psc_pkg::psc_mode_s mode_i,
  input wire psc_pkg::psc_pins_s pins_i,
  input wire logic               wait_n_o,
  input wire logic               wait_oe_n_o,
  input wire logic               dq_oe_n_o,
  input wire logic               word_strobe_o,
  input wire logic               word_is_write_o,
  input wire logic [ADDR_W-1:0]  word_addr_o
);
  logic              prv;
  logic [ADDR_W-1:0] pa;
  always_ff @(posedge sys_clk_i) begin
    prv <= rst_n_i && !pins_i.chip_select_n && (prv || word_strobe_o);
    if (word_strobe_o) pa <= word_addr_o;
  end
  wire [ADDR_W-1:0] nc = pa + 1'b1;
  wire [1:0]        bl = mode_i.burst_length_field;
  wire [ADDR_W-1:0] nx = (bl == psc_pkg::BL_8) ? {pa[ADDR_W-1:3], nc[2:0]} :
                         (bl == psc_pkg::BL_16) ? {pa[ADDR_W-1:4], nc[3:0]} : nc;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_idle; pins_i.chip_select_n [*6]; endsequence
  sequence s_oe_up; pins_i.oe_n [*8]; endsequence
  sequence s_we_up; (pins_i.we_n && mode_i.write_enable_style) [*8]; endsequence
  AST_IDLE_FLOAT: assert property (s_idle |-> wait_oe_n_o)
    else $error("wait driven while deselected");
  AST_ASYNC_FLOAT: assert property (!mode_i.sync_mode |-> wait_oe_n_o)
    else $error("wait driven in async mode");
  AST_SELECT_BUSY: assert property ($fell(pins_i.chip_select_n) && mode_i.sync_mode
    |-> ##[1:8] (!wait_oe_n_o && !wait_n_o)) else $error("no busy after select");
  AST_READY_FIRST: assert property (word_strobe_o |-> $past(wait_n_o, 4))
    else $error("word without ready");
  AST_LINEAR: assert property (word_strobe_o && prv |-> word_addr_o == nx)
    else $error("burst address out of sequence");
  AST_SINGLE_WR: assert property (word_strobe_o && word_is_write_o
    && mode_i.single_write_select |-> !prv) else $error("second single write");
  AST_RD_SUSPEND: assert property (s_oe_up |-> dq_oe_n_o
    && !(word_strobe_o && !word_is_write_o)) else $error("read not suspended");
  AST_WR_SUSPEND: assert property (s_we_up |-> !(word_strobe_o && word_is_write_o))
    else $error("write not suspended");
endmodule // psc_burst_ctrl_chk
bind psc_burst_ctrl psc_burst_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (.sys_clk_i, .rst_n_i,
  .mode_i, .pins_i, .wait_n_o, .wait_oe_n_o, .dq_oe_n_o, .word_strobe_o, .word_is_write_o,
  .word_addr_o);

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic               sys_clk_i = 1'b0;
  logic               rst_n_i = 1'b0;
  logic               go = 1'b0;
  logic               we_n = 1'b1;
  logic               oe_n = 1'b1;
  logic               exp_wr = 1'b0;
  logic [22:0]        a = 23'h0;
  logic [22:0]        ha;
  logic [22:0]        wa;
  logic               stb;
  logic               isw;
  logic               woe;
  logic               busy;
  psc_pkg::psc_mode_s md = '0;
  psc_pkg::psc_pins_s pins;
  int                 err_total = 0;
  int                 n_checks = 0;
  logic [22:0]        aq[$];
  realtime            tq[$];
  realtime            t0;
  realtime            t_rd;
  initial forever #12.5 sys_clk_i = !sys_clk_i;
  psc_host_model HOST (.sys_clk_i, .go_i(go), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(a),
    .pins_o(pins), .addr_o(ha));
  psc_burst_ctrl DUT (.sys_clk_i, .rst_n_i, .mode_i(md), .pins_i(pins), .addr_i(ha),
    .wait_n_o(), .wait_oe_n_o(woe), .dq_oe_n_o(), .word_strobe_o(stb), .word_is_write_o(isw),
    .word_addr_o(wa), .busy_o(busy));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(negedge sys_clk_i) if (stb) begin
    aq.push_back(wa);
    tq.push_back($realtime);
    check(32'(isw), 32'(exp_wr));
  end
  // Suspend window lands mid-burst, well after the first word
  task automatic burst(input logic [22:0] adr, input logic wr, input int n, input int sus);
    logic sp;
    aq.delete();
    tq.delete();
    t0 = $realtime;
    exp_wr = wr;
    a <= adr;
    go <= 1'b1;
    for (int i = 0; i < 8 * n; i++) begin
      sp = sus > 0 && i >= 8 * sus && i < 8 * sus + 24;
      oe_n <= wr || sp;
      we_n <= !wr || sp;
      @(negedge sys_clk_i);
    end
    go <= 1'b0;
    we_n <= 1'b1;
    oe_n <= 1'b1;
    repeat (40) @(negedge sys_clk_i);
    check(32'(busy), 32'h0);
    check(32'(woe), 32'h1);
  endtask
  task automatic expect_seq(input logic [22:0] adr, input logic [22:0] msk, input int n);
    check(msk == '1 ? 32'(aq.size() >= n) : 32'(aq.size()), msk == '1 ? 32'h1 : 32'(n));
    for (int i = 0; i < n && i < aq.size(); i++)
      check(32'(aq[i]), 32'((adr & ~msk) | ((adr + 23'(i)) & msk)));
  endtask
  task automatic t_read8;
    md <= '{1'b1, 1'b0, 1'b1, psc_pkg::BL_8, 4'h5};
    burst(23'h000105, 1'b0, 20, 9);
    expect_seq(23'h000105, 23'h7, 8);
    t_rd = tq[0] - t0;
  endtask
  task automatic t_write8;
    burst(23'h00020e, 1'b1, 20, 9);
    expect_seq(23'h00020e, 23'h7, 8);
    check(32'(int'((t_rd - (tq[0] - t0)) / 200.0)), 32'h1);
  endtask
  task automatic t_cont;
    md <= '{1'b1, 1'b0, 1'b1, psc_pkg::BL_CONT, 4'h5};
    burst(23'h00003b, 1'b0, 20, 0);
    expect_seq(23'h00003b, '1, 8);
    check(32'(int'((tq[5] - tq[4]) / 200.0)), 32'h2);
  endtask
  task automatic t_single;
    md <= '{1'b1, 1'b1, 1'b1, psc_pkg::BL_16, 4'h5};
    burst(23'h000300, 1'b1, 16, 0);
    expect_seq(23'h000300, 23'hf, 1);
  endtask
  task automatic t_async;
    md <= '{1'b0, 1'b0, 1'b1, psc_pkg::BL_8, 4'h5};
    burst(23'h000000, 1'b0, 10, 0);
    check(32'(aq.size()), 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(negedge sys_clk_i);
    t_read8;
    t_write8;
    t_cont;
    t_single;
    t_async;
    tally_and_finish;
  end
  initial begin
    #100us;
    err_total++;
    tally_and_finish;
  end
endmodule // tb_top
